// ===== logic/pfm_config.sv
// Port framing mode configuration: APB register bank, decode and 8 kHz reference select
//
// Overview of operation
// - Line-mode bit forces unipolar coding; else zero-suppress disable picks B3ZS/HDB3 or AMI.
// - In PLCP modes bit 7 places cell delineation in cell processor or PLCP framer.
// - Non-PLCP cell modes always delineate in the cell processor.
// - Packet bus mode without PLCP: bit 6 picks packets (0) or cells (1).
// - Packet bus mode with PLCP always processes cells, ignoring bit 6.
// - Framing mode field bits 5..0 picks framing; reset gives DS3 C-bit.
// - DS3 C-bit codes 000000..000110 give the seven framing variants.
// - Codes 001000..001110 give DS3 M23 with the same seven variants.
// - Codes 010000..010110 give E3 G.751 with the same seven variants.
// - Codes 011000..011110 give E3 G.832; 011100 and 011101 are reserved.
// - Leading 1 gives clear channel DS3, STS-1 or E3 with plain/mask/octet.
// - Overhead-mask modes are unipolar only; PLCP modes carry cells only.
// - Bit 13 picks receive clock output or gapped/overhead/low function.
// - Bit 12 picks receive data-enable (0) or start-of-frame (1).
// - Bit 11 enables the receive PLCP/fractional port pins.
// - Bit 10 picks transmit clock output or gapped/overhead/low function.
// - Bit 9 picks transmit data-enable (0) or start-of-frame (1).
// - Bit 8 enables the transmit PLCP/fractional port pins.
// - Bits 7..6 choose this port's 8 kHz reference, usable globally.
// - Reference code 0X is PLCP 8 kHz, 10 line clock, 11 framer clock.
// - Bit 5 feeds trailer and timer from global (0) or port (1) reference.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module pfm_config import pfm_pkg::*; #(
  parameter int NPORTS = PFM_NPORTS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PFM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System bus mode
  input wire logic packet_bus_mode,
  // 8 kHz reference sources
  input wire logic [NPORTS-1:0] rx_plcp_8k,
  input wire logic [NPORTS-1:0] rx_line_clk,
  input wire logic [NPORTS-1:0] tx_framer_clk,
  input wire logic global_ref_8k,
  // Framing and processing, per port
  output pfm_family_t [NPORTS-1:0] framing_family,
  output pfm_variant_t [NPORTS-1:0] framing_variant,
  output logic [NPORTS-1:0] mode_valid,
  output pfm_lcode_t [NPORTS-1:0] tx_line_code,
  output pfm_lcode_t [NPORTS-1:0] rx_line_code,
  output logic [NPORTS-1:0] plcp_mode,
  output logic [NPORTS-1:0] delineate_in_plcp,
  output logic [NPORTS-1:0] cell_processing,
  // Pin functions, per port
  output pfm_clkfn_t [NPORTS-1:0] rx_clk_pin_fn,
  output logic [NPORTS-1:0] rx_frame_pin_sof,
  output logic [NPORTS-1:0] rx_frac_port_en,
  output pfm_clkfn_t [NPORTS-1:0] tx_clk_pin_fn,
  output logic [NPORTS-1:0] tx_frame_pin_sof,
  output logic [NPORTS-1:0] tx_frac_port_en,
  // 8 kHz references, per port
  output logic [NPORTS-1:0] port_ref_8k,
  output logic [NPORTS-1:0] timer_ref_8k
);

  // ==========================================================================
  // State
  localparam int SW = 3 * NPORTS + 1;

  typedef struct packed {
    logic [NPORTS-1:0][15:0] cr2;
    logic [NPORTS-1:0][15:0] cr3;
    logic [NPORTS-1:0][15:0] lc;
    pfm_family_t [NPORTS-1:0] family;
    pfm_variant_t [NPORTS-1:0] variant;
    logic [NPORTS-1:0] valid;
    pfm_lcode_t [NPORTS-1:0] tx_lc;
    pfm_lcode_t [NPORTS-1:0] rx_lc;
    logic [NPORTS-1:0] plcp;
    logic [NPORTS-1:0] delin;
    logic [NPORTS-1:0] cellp;
    pfm_clkfn_t [NPORTS-1:0] rx_clk;
    logic [NPORTS-1:0] rx_sof;
    logic [NPORTS-1:0] rx_fpe;
    pfm_clkfn_t [NPORTS-1:0] tx_clk;
    logic [NPORTS-1:0] tx_sof;
    logic [NPORTS-1:0] tx_fpe;
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [NPORTS-1:0] pref;
    logic [NPORTS-1:0] tref;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } pfm_state_t;

  pfm_state_t st_q;
  pfm_state_t st_d;

  // ==========================================================================
  // Decoders
  pfm_family_t [NPORTS-1:0] dec_fam;
  pfm_variant_t [NPORTS-1:0] dec_var;
  logic [NPORTS-1:0] dec_valid;
  pfm_lcode_t [NPORTS-1:0] dec_txlc;
  pfm_lcode_t [NPORTS-1:0] dec_rxlc;
  logic [NPORTS-1:0] dec_plcp;
  logic [NPORTS-1:0] dec_delin;
  logic [NPORTS-1:0] dec_cellp;
  pfm_clkfn_t [NPORTS-1:0] dec_rxclk;
  pfm_clkfn_t [NPORTS-1:0] dec_txclk;

  for (genvar gp = 0; gp < NPORTS; gp++) begin : g_dec
    pfm_decode u_dec (
      .cr2(st_q.cr2[gp]),
      .cr3(st_q.cr3[gp]),
      .lc(st_q.lc[gp]),
      .packet_bus_mode(packet_bus_mode),
      .family(dec_fam[gp]),
      .variant(dec_var[gp]),
      .valid(dec_valid[gp]),
      .tx_lc(dec_txlc[gp]),
      .rx_lc(dec_rxlc[gp]),
      .plcp(dec_plcp[gp]),
      .delin_plcp(dec_delin[gp]),
      .cell_proc(dec_cellp[gp]),
      .rx_clk(dec_rxclk[gp]),
      .tx_clk(dec_txclk[gp])
    );
  end

  // ==========================================================================
  // Address decode
  logic [10:0] idx;
  logic [1:0] aport;
  logic [8:0] aoff;
  logic hit;
  logic setup;
  logic wr_now;

  assign idx = paddr[PFM_ADDR_W-1:2];
  assign aport = idx[10:PFM_PORT_LSB];
  assign aoff = idx[PFM_PORT_LSB-1:0];
  assign hit = (paddr[1:0] == 2'h0) && (int'(aport) < NPORTS)
               && (aoff inside {PFM_IDX_CR2, PFM_IDX_CR3, PFM_IDX_LC, PFM_IDX_ST});
  assign setup = psel && !penable;
  // Write lands on the completing edge only
  assign wr_now = psel && penable && st_q.rdy && pwrite && hit;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    if (be[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (be[1]) begin
      nv[15:8] = wd[15:8];
    end
    return nv & mask;
  endfunction : merge

  function automatic logic [15:0] status_word(input pfm_state_t s, input int p);
    return {s.tref[p], s.pref[p], s.cellp[p], s.delin[p], s.plcp[p], s.rx_lc[p],
            s.tx_lc[p], s.valid[p], s.variant[p], s.family[p]};
  endfunction : status_word

  // ==========================================================================
  // Next state
  always_comb begin
    logic [15:0] rw;
    logic ps;
    rw = PFM_RST;
    ps = 1'h0;
    st_d = st_q;
    st_d.s1 = {global_ref_8k, tx_framer_clk, rx_line_clk, rx_plcp_8k};
    st_d.s2 = st_q.s1;
    // Zero wait state: ready in the first access cycle
    st_d.rdy = setup;
    st_d.err = setup && !hit;
    if (setup) begin
      case (aoff)
        PFM_IDX_CR2: rw = st_q.cr2[aport];
        PFM_IDX_CR3: rw = st_q.cr3[aport];
        PFM_IDX_LC: rw = st_q.lc[aport];
        PFM_IDX_ST: rw = status_word(st_q, int'(aport));
        default: rw = PFM_RST;
      endcase
      st_d.rdata = hit ? {16'h0000, rw} : 32'h0000_0000;
    end
    if (wr_now) begin
      case (aoff)
        PFM_IDX_CR2: st_d.cr2[aport] = merge(st_q.cr2[aport], pwdata, pstrb, PFM_CR2_MASK);
        PFM_IDX_CR3: st_d.cr3[aport] = merge(st_q.cr3[aport], pwdata, pstrb, PFM_CR3_MASK);
        PFM_IDX_LC: st_d.lc[aport] = merge(st_q.lc[aport], pwdata, pstrb, PFM_LC_MASK);
        default: st_d.lc = st_q.lc;
      endcase
    end
    for (int p = 0; p < NPORTS; p++) begin
      st_d.family[p] = dec_fam[p];
      st_d.variant[p] = dec_var[p];
      st_d.valid[p] = dec_valid[p];
      st_d.tx_lc[p] = dec_txlc[p];
      st_d.rx_lc[p] = dec_rxlc[p];
      st_d.plcp[p] = dec_plcp[p];
      st_d.delin[p] = dec_delin[p];
      st_d.cellp[p] = dec_cellp[p];
      st_d.rx_clk[p] = dec_rxclk[p];
      st_d.rx_sof[p] = st_q.cr3[p][PFM_CR3_RXFRM];
      st_d.rx_fpe[p] = st_q.cr3[p][PFM_CR3_RXFPE];
      st_d.tx_clk[p] = dec_txclk[p];
      st_d.tx_sof[p] = st_q.cr3[p][PFM_CR3_TXFRM];
      st_d.tx_fpe[p] = st_q.cr3[p][PFM_CR3_TXFPE];
      // Port reference from synchronised sources
      if (!st_q.cr3[p][PFM_CR3_REF_HI]) begin
        ps = st_q.s2[p];
      end else if (!st_q.cr3[p][PFM_CR3_REF_LO]) begin
        ps = st_q.s2[NPORTS + p];
      end else begin
        ps = st_q.s2[2 * NPORTS + p];
      end
      st_d.pref[p] = ps;
      st_d.tref[p] = st_q.cr3[p][PFM_CR3_REFLOC] ? ps : st_q.s2[3 * NPORTS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = st_q.rdata;
  assign pready = st_q.rdy;
  assign pslverr = st_q.err;
  assign framing_family = st_q.family;
  assign framing_variant = st_q.variant;
  assign mode_valid = st_q.valid;
  assign tx_line_code = st_q.tx_lc;
  assign rx_line_code = st_q.rx_lc;
  assign plcp_mode = st_q.plcp;
  assign delineate_in_plcp = st_q.delin;
  assign cell_processing = st_q.cellp;
  assign rx_clk_pin_fn = st_q.rx_clk;
  assign rx_frame_pin_sof = st_q.rx_sof;
  assign rx_frac_port_en = st_q.rx_fpe;
  assign tx_clk_pin_fn = st_q.tx_clk;
  assign tx_frame_pin_sof = st_q.tx_sof;
  assign tx_frac_port_en = st_q.tx_fpe;
  assign port_ref_8k = st_q.pref;
  assign timer_ref_8k = st_q.tref;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam logic [PFM_ADDR_W-1:0] CR3_P0 = {2'h0, PFM_IDX_CR3, 2'h0};

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wr_cr3_p0;
    psel && penable && pready && pwrite && paddr == CR3_P0 && pstrb[1:0] == 2'h3;
  endsequence

  AST_APB_READY: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not one access cycle after setup");

  AST_CR3_WRITE: assert property (s_wr_cr3_p0 |=>
      st_q.cr3[0] == ($past(pwdata[15:0]) & PFM_CR3_MASK) ##1 rx_frac_port_en[0]
      == st_q.cr3[0][PFM_CR3_RXFPE])
    else $error("pin control write not applied");

  AST_PORT_ISOLATION: assert property (wr_now && aport != 2'h0 |=> $stable(st_q.cr3[0])
      && $stable(st_q.cr2[0]))
    else $error("write to other port changed port 0");

  AST_UNI_LINE: assert property (st_q.cr2[0][PFM_CR2_LM] |=>
      tx_line_code[0] == PFM_LC_UNI && rx_line_code[0] == PFM_LC_UNI)
    else $error("line mode did not force unipolar");

  AST_AMI_LINE: assert property (!st_q.cr2[0][PFM_CR2_LM] && st_q.cr2[0][5:0] == 6'h00
      && st_q.lc[0][PFM_LC_TXZSD] |=> tx_line_code[0] == PFM_LC_AMI)
    else $error("zero suppress disable did not give AMI");

  AST_OHM_UNI: assert property (mode_valid[0] && framing_variant[0] inside
      {PFM_VAR_OHM, PFM_VAR_PLCP_OHM, PFM_VAR_OHM_OCTET} |-> tx_line_code[0] == PFM_LC_UNI)
    else $error("overhead mask mode not unipolar");

  AST_PLCP_CELLS: assert property (plcp_mode[0] |-> cell_processing[0])
    else $error("PLCP mode carrying packets");

  AST_DELIN_PLCP: assert property (dec_plcp[0] && st_q.cr2[0][PFM_CR2_CDD]
      |=> delineate_in_plcp[0])
    else $error("delineation not moved to PLCP framer");

  AST_DELIN_CELL: assert property (!dec_plcp[0] |=> !delineate_in_plcp[0])
    else $error("delineator left cell processor outside PLCP");

  AST_PACKET_SEL: assert property (packet_bus_mode && !dec_plcp[0]
      && !st_q.cr2[0][PFM_CR2_CPS] |=> !cell_processing[0])
    else $error("packet processing not selected");

  AST_PLCP_FORCE: assert property (packet_bus_mode && dec_plcp[0] |=> cell_processing[0])
    else $error("PLCP in packet bus mode not cell processing");

  AST_G832_RSVD: assert property (st_q.cr2[0][5:0] == 6'h1c |=> !mode_valid[0]
      && !plcp_mode[0])
    else $error("reserved code decoded as valid");

  AST_REF_LINE: assert property (st_q.cr3[0][7:6] == 2'h2 |=>
      port_ref_8k[0] == $past(st_q.s2[NPORTS]))
    else $error("line clock reference not selected");

  AST_TIMER_GLOBAL: assert property (!st_q.cr3[0][PFM_CR3_REFLOC] |=>
      timer_ref_8k[0] == $past(st_q.s2[3 * NPORTS]))
    else $error("timer reference not global");

endmodule : pfm_config

// ===== logic/pfm_pkg.sv
// Constants and types for the port framing mode configuration block
package pfm_pkg;

  // ==========================================================================
  // Sizes
  localparam int PFM_NPORTS = 4;
  localparam int PFM_ADDR_W = 13;
  localparam int PFM_REG_W = 16;

  // ==========================================================================
  // Register indexes within one port (byte address is four times the index)
  localparam logic [8:0] PFM_IDX_CR2 = 9'h042;
  localparam logic [8:0] PFM_IDX_CR3 = 9'h044;
  localparam logic [8:0] PFM_IDX_LC = 9'h04c;
  localparam logic [8:0] PFM_IDX_ST = 9'h04e;
  localparam int PFM_PORT_LSB = 9;

  // ==========================================================================
  // Framing and processing control fields
  localparam int PFM_CR2_LM = 10;
  localparam int PFM_CR2_CDD = 7;
  localparam int PFM_CR2_CPS = 6;
  localparam int PFM_CR2_FM_HI = 5;
  localparam logic [15:0] PFM_CR2_MASK = 16'h04ff;

  // ==========================================================================
  // Pin and reference control fields
  localparam int PFM_CR3_RXCLK = 13;
  localparam int PFM_CR3_RXFRM = 12;
  localparam int PFM_CR3_RXFPE = 11;
  localparam int PFM_CR3_TXCLK = 10;
  localparam int PFM_CR3_TXFRM = 9;
  localparam int PFM_CR3_TXFPE = 8;
  localparam int PFM_CR3_REF_HI = 7;
  localparam int PFM_CR3_REF_LO = 6;
  localparam int PFM_CR3_REFLOC = 5;
  localparam logic [15:0] PFM_CR3_MASK = 16'h3fe0;

  // ==========================================================================
  // Line code control fields
  localparam int PFM_LC_TXZSD = 0;
  localparam int PFM_LC_RXZSD = 1;
  localparam logic [15:0] PFM_LC_MASK = 16'h0003;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] PFM_RST = 16'h0000;

  // ==========================================================================
  // Decoded modes
  typedef enum logic [2:0] {
    PFM_FAM_CBIT, PFM_FAM_M23, PFM_FAM_G751, PFM_FAM_G832,
    PFM_FAM_CC_DS3, PFM_FAM_CC_STS1, PFM_FAM_CC_E3
  } pfm_family_t;

  typedef enum logic [2:0] {
    PFM_VAR_PLAIN, PFM_VAR_OHM, PFM_VAR_INT_FRAC, PFM_VAR_EXT_FRAC,
    PFM_VAR_PLCP, PFM_VAR_PLCP_OHM, PFM_VAR_FLEX_FRAC, PFM_VAR_OHM_OCTET
  } pfm_variant_t;

  typedef enum logic [1:0] {PFM_LC_ZS, PFM_LC_AMI, PFM_LC_UNI} pfm_lcode_t;

  typedef enum logic [1:0] {
    PFM_CLK_LOW, PFM_CLK_GAPPED, PFM_CLK_PLCP_OH, PFM_CLK_OUT
  } pfm_clkfn_t;

endpackage : pfm_pkg

// ===== logic/pfm_decode.sv
// Per-port decoder from control words to framing and pin functions
`timescale 1ns/1ns
module pfm_decode import pfm_pkg::*; (
  // Control words
  input wire logic [15:0] cr2,
  input wire logic [15:0] cr3,
  input wire logic [15:0] lc,
  // System bus mode
  input wire logic packet_bus_mode,
  // Decoded
  output pfm_family_t family,
  output pfm_variant_t variant,
  output logic valid,
  output pfm_lcode_t tx_lc,
  output pfm_lcode_t rx_lc,
  output logic plcp,
  output logic delin_plcp,
  output logic cell_proc,
  output pfm_clkfn_t rx_clk,
  output pfm_clkfn_t tx_clk
);

  logic [5:0] fm;
  logic overhead_mask;
  logic frac;

  function automatic pfm_lcode_t line_code(input logic lm, input logic om, input logic zsd);
    if (lm || om) begin
      return PFM_LC_UNI;
    end
    return zsd ? PFM_LC_AMI : PFM_LC_ZS;
  endfunction : line_code

  function automatic pfm_clkfn_t clk_fn(input logic sel, input logic fpe, input logic pl,
                                        input logic fr);
    if (sel) begin
      return PFM_CLK_OUT;
    end
    if (fpe && pl) begin
      return PFM_CLK_PLCP_OH;
    end
    if (fpe && fr) begin
      return PFM_CLK_GAPPED;
    end
    return PFM_CLK_LOW;
  endfunction : clk_fn

  assign fm = cr2[PFM_CR2_FM_HI:0];

  always_comb begin
    family = PFM_FAM_CBIT;
    variant = PFM_VAR_PLAIN;
    valid = 1'h1;
    if (!fm[5]) begin
      family = pfm_family_t'({1'h0, fm[4:3]});
      case (fm[2:0])
        3'h0: variant = PFM_VAR_PLAIN;
        3'h1: variant = PFM_VAR_OHM;
        3'h2: variant = PFM_VAR_INT_FRAC;
        3'h3: variant = PFM_VAR_EXT_FRAC;
        3'h4: variant = PFM_VAR_PLCP;
        3'h5: variant = PFM_VAR_PLCP_OHM;
        3'h6: variant = PFM_VAR_FLEX_FRAC;
        default: valid = 1'h0;
      endcase
      if (fm[4:3] == 2'h3 && fm[2:1] == 2'h2) begin
        valid = 1'h0;
      end
    end else begin
      if (fm[4]) begin
        family = PFM_FAM_CC_E3;
      end else if (fm[3]) begin
        family = PFM_FAM_CC_STS1;
      end else begin
        family = PFM_FAM_CC_DS3;
      end
      case (fm[1:0])
        2'h1: variant = PFM_VAR_OHM;
        2'h3: variant = PFM_VAR_OHM_OCTET;
        default: variant = PFM_VAR_PLAIN;
      endcase
      if (fm[2]) begin
        valid = 1'h0;
      end
    end
  end

  assign overhead_mask = valid && (variant inside {PFM_VAR_OHM, PFM_VAR_PLCP_OHM, PFM_VAR_OHM_OCTET});
  assign plcp = valid && !fm[5] && (variant inside {PFM_VAR_PLCP, PFM_VAR_PLCP_OHM});
  assign frac = valid && (variant inside {PFM_VAR_INT_FRAC, PFM_VAR_EXT_FRAC,
                                          PFM_VAR_FLEX_FRAC});
  // Overhead-mask modes are unipolar only
  assign tx_lc = line_code(cr2[PFM_CR2_LM], overhead_mask, lc[PFM_LC_TXZSD]);
  assign rx_lc = line_code(cr2[PFM_CR2_LM], overhead_mask, lc[PFM_LC_RXZSD]);
  assign delin_plcp = plcp && cr2[PFM_CR2_CDD];
  // Cells outside the packet-capable bus mode, in PLCP modes, or when bit 6 selects cells
  assign cell_proc = plcp || !packet_bus_mode || cr2[PFM_CR2_CPS];
  assign rx_clk = clk_fn(cr3[PFM_CR3_RXCLK], cr3[PFM_CR3_RXFPE], plcp, frac);
  assign tx_clk = clk_fn(cr3[PFM_CR3_TXCLK], cr3[PFM_CR3_TXFPE], plcp, frac);

endmodule : pfm_decode

// ===== tb/test_port_framing_mode_config.sv
// Self-checking bench for the port framing mode configuration block
`timescale 1ns/1ns
module test_port_framing_mode_config import pfm_pkg::*;;
  // ==========================================================================
  // Stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PFM_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic packet_bus_mode = 1'b0;
  logic [3:0] rx_plcp_8k = '0;
  logic [3:0] rx_line_clk = '0;
  logic [3:0] tx_framer_clk = '0;
  logic global_ref_8k = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pfm_family_t [3:0] framing_family;
  pfm_variant_t [3:0] framing_variant;
  pfm_lcode_t [3:0] tx_line_code;
  pfm_lcode_t [3:0] rx_line_code;
  pfm_clkfn_t [3:0] rx_clk_pin_fn;
  pfm_clkfn_t [3:0] tx_clk_pin_fn;
  logic [3:0] mode_valid, plcp_mode, delineate_in_plcp, cell_processing;
  logic [3:0] rx_frame_pin_sof, rx_frac_port_en, tx_frame_pin_sof, tx_frac_port_en;
  logic [3:0] port_ref_8k, timer_ref_8k;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] rnd = 32'h395a6b79;
  logic [6:0] m;
  logic [11:0] pt [7] = '{12'hc00, 12'hb00, 12'hdc4, 12'h954, 12'h100, 12'hfcd, 12'h508};
  logic [5:0] fl [3] = '{6'h00, 6'h04, 6'h02};
  logic s;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int p, c, v, k, i;

  pfm_config #(.NPORTS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .packet_bus_mode(packet_bus_mode),
    .rx_plcp_8k(rx_plcp_8k), .rx_line_clk(rx_line_clk), .tx_framer_clk(tx_framer_clk),
    .global_ref_8k(global_ref_8k), .framing_family(framing_family),
    .framing_variant(framing_variant), .mode_valid(mode_valid), .tx_line_code(tx_line_code),
    .rx_line_code(rx_line_code), .plcp_mode(plcp_mode), .delineate_in_plcp(delineate_in_plcp),
    .cell_processing(cell_processing), .rx_clk_pin_fn(rx_clk_pin_fn),
    .rx_frame_pin_sof(rx_frame_pin_sof), .rx_frac_port_en(rx_frac_port_en),
    .tx_clk_pin_fn(tx_clk_pin_fn), .tx_frame_pin_sof(tx_frame_pin_sof),
    .tx_frac_port_en(tx_frac_port_en), .port_ref_8k(port_ref_8k), .timer_ref_8k(timer_ref_8k));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [12:0] ra(input int pn, input logic [8:0] idx);
    return {pn[1:0], idx, 2'b00};
  endfunction : ra

  // Expected {valid, family, variant} of a framing code
  function automatic logic [6:0] exp_mode(input logic [5:0] fm);
    logic [2:0] f;
    logic [2:0] vr;
    logic ok;
    if (!fm[5]) begin
      f = {1'b0, fm[4:3]};
      vr = fm[2:0];
      ok = (vr != 3'd7) && !(f == 3'd3 && vr[2:1] == 2'b10);
    end else begin
      f = fm[4] ? PFM_FAM_CC_E3 : (fm[3] ? PFM_FAM_CC_STS1 : PFM_FAM_CC_DS3);
      vr = !fm[0] ? PFM_VAR_PLAIN : (fm[1] ? PFM_VAR_OHM_OCTET : PFM_VAR_OHM);
      ok = !fm[2];
    end
    return {ok, f, vr};
  endfunction : exp_mode

  function automatic logic [1:0] clkfn(input logic sel, input logic en, input logic [5:0] fm);
    if (sel) return PFM_CLK_OUT;
    if (en && fm == 6'h04) return PFM_CLK_PLCP_OH;
    if (en && fm == 6'h02) return PFM_CLK_GAPPED;
    return PFM_CLK_LOW;
  endfunction : clkfn

  task end_sim;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [31:0] ed,
           input logic ee);
    exp_q.push_back({~w, ee, ed});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? 4'h3 : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until ready is seen at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input int pn, input logic [8:0] idx, input logic [31:0] d);
    apb(1'b1, ra(pn, idx), d, 32'h0, 1'b0);
  endtask : wr

  task settle(input int n);
    repeat (n) @(negedge pclk);
  endtask : settle

  // ==========================================================================
  // Answer monitor, oldest note first
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1, "unexpected answer");
      else begin
        e = exp_q.pop_front();
        chk(pslverr, e[32], "pslverr");
        if (e[33]) chk(prdata, e[31:0], "prdata");
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (p = 0; p < 4; p++) begin
      apb(1'b0, ra(p, PFM_IDX_CR2), 32'h0, {16'h0, PFM_RST}, 1'b0);
      apb(1'b0, ra(p, PFM_IDX_CR3), 32'h0, {16'h0, PFM_RST}, 1'b0);
      chk(framing_family[p], PFM_FAM_CBIT, "reset family");
      chk(framing_variant[p], PFM_VAR_PLAIN, "reset variant");
    end
    wr(2, PFM_IDX_CR2, 32'hffffffff);
    wr(2, PFM_IDX_CR3, 32'hffffffff);
    apb(1'b0, ra(2, PFM_IDX_CR2), 32'h0, {16'h0, PFM_CR2_MASK}, 1'b0);
    apb(1'b0, ra(2, PFM_IDX_CR3), 32'h0, {16'h0, PFM_CR3_MASK}, 1'b0);
    wr(0, PFM_IDX_CR3, 32'h3fbf);
    apb(1'b0, ra(0, PFM_IDX_CR3), 32'h0, {16'h0, 16'h3fbf & PFM_CR3_MASK}, 1'b0);
    apb(1'b0, ra(1, PFM_IDX_CR2), 32'h0, 32'h0, 1'b0);
    apb(1'b0, ra(0, 9'h050), 32'h0, 32'h0, 1'b1);
    apb(1'b1, ra(0, PFM_IDX_CR2) | 13'h1, 32'h3f, 32'h0, 1'b1);
    apb(1'b0, ra(0, PFM_IDX_CR2), 32'h0, 32'h0, 1'b0);
    wr(2, PFM_IDX_CR2, 32'h0);
    wr(2, PFM_IDX_CR3, 32'h0);
    // Every framing code on a random port, bits 31..11 noisy
    for (c = 0; c < 64; c++) begin
      rnd = lfsr(rnd);
      p = int'(rnd[1:0]);
      wr(p, PFM_IDX_CR2, {rnd[31:11], 5'h0, c[5:0]});
      settle(2);
      m = exp_mode(c[5:0]);
      chk(mode_valid[p], m[6], "mode valid");
      if (m[6]) begin
        chk(framing_family[p], m[5:3], "family");
        chk(framing_variant[p], m[2:0], "variant");
      end
    end
    // Line codes
    for (i = 0; i < 8; i++) begin
      wr(0, PFM_IDX_LC, {30'h0, i[1:0]});
      wr(0, PFM_IDX_CR2, {21'h0, i[2], 10'h0});
      settle(2);
      chk(tx_line_code[0], i[2] ? PFM_LC_UNI : (i[0] ? PFM_LC_AMI : PFM_LC_ZS), "tx lc");
      chk(rx_line_code[0], i[2] ? PFM_LC_UNI : (i[1] ? PFM_LC_AMI : PFM_LC_ZS), "rx lc");
    end
    wr(0, PFM_IDX_LC, 32'h0);
    wr(0, PFM_IDX_CR2, 32'h1);
    settle(2);
    chk(tx_line_code[0], PFM_LC_UNI, "mask tx lc");
    chk(rx_line_code[0], PFM_LC_UNI, "mask rx lc");
    // Processing and delineation
    for (i = 0; i < 7; i++) begin
      @(posedge pclk);
      packet_bus_mode <= pt[i][11];
      wr(0, PFM_IDX_CR2, {24'h0, pt[i][10:9], pt[i][5:0]});
      settle(3);
      chk(cell_processing[0], pt[i][8], "cell processing");
      chk(delineate_in_plcp[0], pt[i][7], "delineation");
      chk(plcp_mode[0], pt[i][6], "plcp mode");
    end
    wr(0, PFM_IDX_CR2, 32'h1c);
    settle(2);
    chk(mode_valid[0], 1'b0, "reserved code");
    // Pin functions
    for (c = 0; c < 3; c++) begin
      wr(3, PFM_IDX_CR2, {26'h0, fl[c]});
      for (v = 0; v < 64; v++) begin
        wr(3, PFM_IDX_CR3, {16'h0, 2'b00, v[5:0], 8'h0});
        settle(2);
        chk(rx_clk_pin_fn[3], clkfn(v[5], v[3], fl[c]), "rx clk pin");
        chk(rx_frame_pin_sof[3], v[4], "rx frame pin");
        chk(rx_frac_port_en[3], v[3], "rx port enable");
        chk(tx_clk_pin_fn[3], clkfn(v[2], v[0], fl[c]), "tx clk pin");
        chk(tx_frame_pin_sof[3], v[1], "tx frame pin");
        chk(tx_frac_port_en[3], v[0], "tx port enable");
      end
    end
    // 8 kHz reference selection
    for (k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      p = int'(rnd[23:22]);
      wr(p, PFM_IDX_CR3, {24'h0, k[2:0], 5'h0});
      @(posedge pclk);
      rx_plcp_8k <= rnd[11:8];
      rx_line_clk <= rnd[15:12];
      tx_framer_clk <= rnd[19:16];
      global_ref_8k <= rnd[20];
      settle(5);
      s = !k[2] ? rnd[8 + p] : (k[1] ? rnd[16 + p] : rnd[12 + p]);
      chk(port_ref_8k[p], s, "port reference");
      chk(timer_ref_8k[p], k[0] ? s : rnd[20], "timer reference");
    end
    end_sim();
  end
endmodule : test_port_framing_mode_config
